//--- hw/lldp_pkg.sv
// lowlat dram command/data port: shared constants and types
// ---------------------------------------------------------------
// ---------------------------------------------------------------
package lldp_pkg;
    localparam int         ADDR_W     = 23;
    localparam int         BANK_W     = 3;
    localparam int         DATA_W     = 18;
    localparam int         COL_W      = 4;
    localparam int         FIFO_DEPTH = 8;
    localparam int         BURST_OFF1 = 1;
    // command codes as {we_n, ref_n}
    localparam logic [1:0] CMD_MRS    = 2'h0;
    localparam logic [1:0] CMD_WRITE  = 2'h1;
    localparam logic [1:0] CMD_REF    = 2'h2;
    localparam logic [1:0] CMD_READ   = 2'h3;
    localparam logic       CS_ACTIVE  = 1'h0;
    localparam logic       MASK_DROP  = 1'h1;
    localparam logic       PIN_IDLE   = 1'h1;
    typedef enum logic { LLDP_RD_IDLE, LLDP_RD_BEAT1 } lldp_rd_e;
endpackage : lldp_pkg

//--- hw/lldp_port.sv
// lowlat dram command/data port: dual-clock fifo and device top
`timescale 1ns/1ps

// ---------------------------------------------------------------
// dual-clock fifo, gray pointers
// ---------------------------------------------------------------
module lldp_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 8
) (
    input  wire logic         i_wclk,
    input  wire logic         i_wrst,
    input  wire logic         i_wvalid,
    output logic              o_wready,
    input  wire logic [W-1:0] i_wdata,
    input  wire logic         i_rclk,
    input  wire logic         i_rrst,
    output logic              o_rvalid,
    input  wire logic         i_rready,
    output logic [W-1:0]      o_rdata
);
    localparam int AW = $clog2(DEPTH);
    typedef logic [AW:0] lldp_ptr_t;
    typedef struct packed {
        lldp_ptr_t bin;
        lldp_ptr_t gray;
        lldp_ptr_t sy1;
        lldp_ptr_t sy2;
    } lldp_fptr_s;

    function automatic lldp_ptr_t to_gray(input lldp_ptr_t b);
        to_gray = b ^ (b >> 1);
    endfunction : to_gray

    logic [W-1:0] mem [DEPTH];
    lldp_fptr_s   w_reg, w_next, r_reg, r_next;
    logic         push, pop;

    // full when write gray equals read gray with top two bits inverted
    assign o_wready = (w_reg.gray != {~w_reg.sy2[AW:AW-1], w_reg.sy2[AW-2:0]});
    assign o_rvalid = (r_reg.gray != r_reg.sy2);
    assign o_rdata  = mem[r_reg.bin[AW-1:0]];
    assign push     = i_wvalid && o_wready;
    assign pop      = o_rvalid && i_rready;

    always_comb begin
        w_next      = w_reg;
        w_next.sy1  = r_reg.gray;
        w_next.sy2  = w_reg.sy1;
        if (push) begin
            w_next.bin  = w_reg.bin + 1'b1;
            w_next.gray = to_gray(w_reg.bin + 1'b1);
        end
        if (i_wrst) begin
            w_next = '0;
        end
    end

    always_comb begin
        r_next      = r_reg;
        r_next.sy1  = w_reg.gray;
        r_next.sy2  = r_reg.sy1;
        if (pop) begin
            r_next.bin  = r_reg.bin + 1'b1;
            r_next.gray = to_gray(r_reg.bin + 1'b1);
        end
        if (i_rrst) begin
            r_next = '0;
        end
    end

    always_ff @(posedge i_wclk) begin
        w_reg <= w_next;
        if (push) begin
            mem[w_reg.bin[AW-1:0]] <= i_wdata;
        end
    end

    always_ff @(posedge i_rclk) begin
        r_reg <= r_next;
    end
endmodule : lldp_fifo

// ---------------------------------------------------------------
// device top
// ---------------------------------------------------------------
module lldp_port
    import lldp_pkg::*;
#(
    parameter int DW    = DATA_W,
    parameter int CW    = COL_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic              i_core_clk,
    input  wire logic              i_srst,
    input  wire logic              i_cs_n,
    input  wire logic              i_we_n,
    input  wire logic              i_ref_n,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [BANK_W-1:0] i_bank,
    input  wire logic              i_write_data_clk,
    input  wire logic [DW-1:0]     i_write_data,
    input  wire logic              i_write_mask,
    output logic [DW-1:0]          o_read_data,
    output logic                   o_read_valid,
    output logic                   o_read_data_clk,
    output logic                   o_read_data_clk_n,
    output logic [ADDR_W-1:0]      o_mode_cfg
);
    localparam int IW    = BANK_W + CW;
    localparam int PW    = 2 * (DW + 1);
    localparam int WORDS = 1 << IW;

    typedef logic [IW-1:0] lldp_idx_t;

    typedef struct packed {
        logic              cs_n;
        logic              we_n;
        logic              ref_n;
        logic [ADDR_W-1:0] addr;
        logic [BANK_W-1:0] bank;
        logic [ADDR_W-1:0] cfg;
        logic              win;
        lldp_idx_t         wa;
        lldp_idx_t         ra;
        lldp_rd_e          rd;
        logic [DW-1:0]     q;
        logic              vld;
        logic              qk;
        logic              qk_n;
    } lldp_core_s;

    typedef struct packed {
        logic          rst_s1;
        logic          rst_s2;
        logic          win_s1;
        logic          win_s2;
        logic [DW-1:0] rise_d;
        logic          rise_m;
        logic          have;
    } lldp_link_s;

    // bank picks the upper index bits, low address bits pick the column
    function automatic lldp_idx_t beat_idx(input logic [BANK_W-1:0] bank,
                                           input logic [CW-1:0]     col,
                                           input int                off);
        beat_idx = {bank, col + CW'(off)};
    endfunction : beat_idx

    logic [DW-1:0] mem [WORDS];
    lldp_core_s    c_reg, c_next;
    lldp_link_s    l_reg, l_next;
    logic [DW-1:0] fall_d;
    logic          fall_m;
    logic          sel, rd_go, wr_go, mrs_go, pop, store, we0, we1;
    logic [1:0]    cmd;
    logic          f_wready, f_rvalid;
    logic [PW-1:0] f_rdata;
    logic [DW-1:0] d0, d1, rd_word0;
    logic          m0, m1;

    // ---------------------------------------------------------------
    // link side: write data clock domain
    // ---------------------------------------------------------------
    // falling beat has its own flop; the pair is completed at the next rise
    always_ff @(negedge i_write_data_clk) begin
        fall_d <= i_write_data;
        fall_m <= i_write_mask;
    end

    always_comb begin
        l_next        = l_reg;
        l_next.rst_s1 = i_srst;
        l_next.rst_s2 = l_reg.rst_s1;
        l_next.win_s1 = c_reg.win;
        l_next.win_s2 = l_reg.win_s1;
        l_next.rise_d = i_write_data;
        l_next.rise_m = i_write_mask;
        l_next.have   = 1'b1;
        if (l_reg.rst_s2) begin
            l_next.have   = 1'b0;
            l_next.win_s2 = 1'b0;
        end
    end

    // relies on a free-running write clock; pairs are dropped while the fifo is full
    always_ff @(posedge i_write_data_clk) begin
        l_reg <= l_next;
    end

    lldp_fifo #(
        .W     (PW),
        .DEPTH (DEPTH)
    ) u_fifo (
        .i_wclk   (i_write_data_clk),
        .i_wrst   (l_reg.rst_s2),
        .i_wvalid (l_reg.have && l_reg.win_s2),
        .o_wready (f_wready),
        .i_wdata  ({l_reg.rise_d, l_reg.rise_m, fall_d, fall_m}),
        .i_rclk   (i_core_clk),
        .i_rrst   (i_srst),
        .o_rvalid (f_rvalid),
        .i_rready (pop),
        .o_rdata  (f_rdata)
    );

    // ---------------------------------------------------------------
    // core side: main clock domain
    // ---------------------------------------------------------------
    assign {d0, m0, d1, m1} = f_rdata;
    assign cmd      = {c_reg.we_n, c_reg.ref_n};
    assign sel      = (c_reg.cs_n == CS_ACTIVE);
    assign rd_go    = sel && (cmd == CMD_READ) && (c_reg.rd == LLDP_RD_IDLE);
    assign wr_go    = sel && (cmd == CMD_WRITE) && !c_reg.win;
    assign mrs_go   = sel && (cmd == CMD_MRS);
    assign rd_word0 = mem[beat_idx(c_reg.bank, c_reg.addr[CW-1:0], 0)];
    // single memory port: a read burst stalls the drain, so the fifo can fill
    assign pop      = f_rvalid && !rd_go && (c_reg.rd == LLDP_RD_IDLE);
    assign store    = pop && c_reg.win;
    assign we0      = store && (m0 != MASK_DROP);
    assign we1      = store && (m1 != MASK_DROP);

    always_comb begin
        c_next       = c_reg;
        c_next.cs_n  = i_cs_n;
        c_next.we_n  = i_we_n;
        c_next.ref_n = i_ref_n;
        c_next.addr  = i_addr;
        c_next.bank  = i_bank;
        c_next.qk    = ~c_reg.qk;
        c_next.qk_n  = c_reg.qk;
        c_next.vld   = 1'b0;
        if (mrs_go) begin
            c_next.cfg = c_reg.addr;
        end
        if (wr_go) begin
            c_next.win = 1'b1;
            c_next.wa  = beat_idx(c_reg.bank, c_reg.addr[CW-1:0], 0);
        end else if (store) begin
            c_next.win = 1'b0;
        end
        // a started burst finishes whatever chip select does
        if (rd_go) begin
            c_next.q   = rd_word0;
            c_next.vld = 1'b1;
            c_next.ra  = beat_idx(c_reg.bank, c_reg.addr[CW-1:0], BURST_OFF1);
            c_next.rd  = LLDP_RD_BEAT1;
        end else if (c_reg.rd == LLDP_RD_BEAT1) begin
            c_next.q   = mem[c_reg.ra];
            c_next.vld = 1'b1;
            c_next.rd  = LLDP_RD_IDLE;
        end
        if (i_srst) begin
            c_next       = '0;
            c_next.cs_n  = PIN_IDLE;
            c_next.we_n  = PIN_IDLE;
            c_next.ref_n = PIN_IDLE;
            c_next.qk_n  = 1'b1;
        end
    end

    always_ff @(posedge i_core_clk) begin
        c_reg <= c_next;
        if (we0) begin
            mem[c_reg.wa] <= d0;
        end
        if (we1) begin
            mem[beat_idx(c_reg.wa[IW-1:CW], c_reg.wa[CW-1:0], BURST_OFF1)] <= d1;
        end
    end

    assign o_read_data       = c_reg.q;
    assign o_read_valid      = c_reg.vld;
    assign o_read_data_clk   = c_reg.qk;
    assign o_read_data_clk_n = c_reg.qk_n;
    assign o_mode_cfg        = c_reg.cfg;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_srst);

    sequence s_two_beats;
        o_read_valid ##1 o_read_valid;
    endsequence

    sequence s_burst_end;
        o_read_valid ##1 !o_read_valid;
    endsequence

    chk_rd_two_beats: assert property (rd_go |=> s_two_beats)
        else $error("read burst did not give two valid beats");

    chk_rd_first_word: assert property (rd_go |=> o_read_data == $past(rd_word0))
        else $error("first read beat does not match stored word");

    chk_rd_bank_sel: assert property (rd_go |=> c_reg.ra[IW-1:CW] == $past(c_reg.bank))
        else $error("read burst aimed at wrong bank");

    chk_mrs_load_cfg: assert property (mrs_go |=> o_mode_cfg == $past(c_reg.addr))
        else $error("mode register set did not load the address");

    chk_desel_no_cmd: assert property (c_reg.cs_n |=> $stable(o_mode_cfg) && !$rose(c_reg.win))
        else $error("command taken while deselected");

    chk_burst_runs_on: assert property
        ((c_reg.rd == LLDP_RD_BEAT1 && c_reg.cs_n) |=> s_burst_end or s_two_beats)
        else $error("started read burst cut short by deselect");

    // the clock is held low through reset, so the release edge itself is not a stall
    chk_rclk_free_run: assert property
        (!$past(i_srst) |-> o_read_data_clk != $past(o_read_data_clk))
        else $error("read data clock stalled");

    chk_rclk_compl: assert property (o_read_data_clk_n == !o_read_data_clk)
        else $error("read data clocks not complementary");

    chk_wr_close_win: assert property (store |=> !c_reg.win)
        else $error("write window not closed after store");
endmodule : lldp_port

//--- verification/lldp_ctrl_model.sv
// controller model: free-running write data clock and write beats
`timescale 1ns/1ps
// ---------------------------------------------------------------
// write side of the memory controller
// ---------------------------------------------------------------
module lldp_ctrl_model
    import lldp_pkg::*;
(
    input  wire logic [DATA_W-1:0] i_rise_word,
    input  wire logic [DATA_W-1:0] i_fall_word,
    input  wire logic              i_rise_mask,
    input  wire logic              i_fall_mask,
    output logic                   o_write_data_clk,
    output logic [DATA_W-1:0]      o_write_data,
    output logic                   o_write_mask
);
    // odd offset keeps edges apart from the core clock
    initial begin
        o_write_data_clk = 1'h0;
        o_write_data     = '0;
        o_write_mask     = 1'h0;
        #1.3;
        forever #24 o_write_data_clk = ~o_write_data_clk;
    end
    // beats move mid half-period, never on a sampling edge
    always @(o_write_data_clk) begin
        #12;
        o_write_data = o_write_data_clk ? i_fall_word : i_rise_word;
        o_write_mask = o_write_data_clk ? i_fall_mask : i_rise_mask;
    end
endmodule : lldp_ctrl_model

//--- verification/lldp_port_bench.sv
// self-checking bench for the command/data port
`timescale 1ns/1ps
module lldp_port_bench;
    import lldp_pkg::*;
    logic              clk = 1'h0;
    logic              srst = 1'h1;
    logic              cs_n = 1'h1;
    logic              we_n = 1'h1;
    logic              ref_n = 1'h1;
    logic [ADDR_W-1:0] addr = '0;
    logic [BANK_W-1:0] bank = '0;
    logic [DATA_W-1:0] rise_word = '0;
    logic [DATA_W-1:0] fall_word = '0;
    logic              rise_mask = 1'h0;
    logic              fall_mask = 1'h0;
    logic              dk;
    logic [DATA_W-1:0] wdata;
    logic              wmask;
    logic [DATA_W-1:0] rdata;
    logic              rvalid;
    logic              rclk;
    logic              rclk_n;
    logic [ADDR_W-1:0] mode_cfg;
    int                failures = 0;
    int                num_checks = 0;
    int                cycles = 0;

    lldp_port u_lldp_port (
        .i_core_clk(clk), .i_srst(srst), .i_cs_n(cs_n), .i_we_n(we_n), .i_ref_n(ref_n),
        .i_addr(addr), .i_bank(bank), .i_write_data_clk(dk), .i_write_data(wdata),
        .i_write_mask(wmask), .o_read_data(rdata), .o_read_valid(rvalid),
        .o_read_data_clk(rclk), .o_read_data_clk_n(rclk_n), .o_mode_cfg(mode_cfg));
    lldp_ctrl_model u_lldp_ctrl_model (
        .i_rise_word(rise_word), .i_fall_word(fall_word), .i_rise_mask(rise_mask),
        .i_fall_mask(fall_mask), .o_write_data_clk(dk), .o_write_data(wdata),
        .o_write_mask(wmask));

    initial begin
        forever #2.5 clk = ~clk;
    end
    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task automatic stop_test;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : stop_test
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            stop_test();
        end
    end
    task automatic check(input logic [ADDR_W-1:0] got, input logic [ADDR_W-1:0] exp,
                         input string what);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check
    // pins held for one rise; on release cs_n goes high and code, address and bank are inverted
    task automatic cmd(input logic c, input logic [1:0] code, input logic [ADDR_W-1:0] a,
                       input logic [BANK_W-1:0] b);
        @(negedge clk);
        cs_n = c;
        {we_n, ref_n} = code;
        addr = a;
        bank = b;
        @(negedge clk);
        cs_n = 1'h1;
        {we_n, ref_n} = ~code;
        addr = ~a;
        bank = ~b;
    endtask : cmd
    task automatic rd_chk(input logic c, input logic [BANK_W-1:0] b, input logic [COL_W-1:0] col,
                          input logic [DATA_W-1:0] e0, input logic [DATA_W-1:0] e1);
        cmd(c, CMD_READ, {19'h7ff00, col}, b);
        // beat0 is registered at the rise after the decode cycle
        @(negedge clk);
        check(rvalid, !c, "valid beat0");
        check(rdata, e0, "beat0");
        @(negedge clk);
        check(rvalid, !c, "valid beat1");
        check(rdata, e1, "beat1");
        @(negedge clk);
        check(rvalid, 1'h0, "valid end");
    endtask : rd_chk
    task automatic wr(input logic [BANK_W-1:0] b, input logic [COL_W-1:0] col,
                      input logic [DATA_W-1:0] w0, input logic [DATA_W-1:0] w1,
                      input logic m0, input logic m1);
        rise_word = w0;
        fall_word = w1;
        rise_mask = m0;
        fall_mask = m1;
        cmd(CS_ACTIVE, CMD_WRITE, {19'h00000, col}, b);
        // long enough for the pair to cross both domains and be stored
        repeat (80) @(negedge clk);
        rise_word = ~w0;
        fall_word = ~w1;
        rise_mask = 1'h0;
        fall_mask = 1'h0;
    endtask : wr
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_idle;
        logic prev;
        prev = rclk;
        check(mode_cfg, 23'h000000, "cfg reset");
        for (int i = 0; i < 8; i++) begin
            @(negedge clk);
            check(rclk, {~prev}, "read clk toggles");
            check(rclk_n, prev, "read clk inverse");
            check(rvalid, 1'h0, "no valid when idle");
            prev = rclk;
        end
        $display("test idle done");
    endtask : t_idle
    task automatic t_cmds;
        cmd(CS_ACTIVE, CMD_MRS, 23'h5a5a5a, 3'h5);
        repeat (2) @(negedge clk);
        check(mode_cfg, 23'h5a5a5a, "mode set");
        cmd(1'h1, CMD_MRS, 23'h7fffff, 3'h0);
        repeat (3) @(negedge clk);
        check(mode_cfg, 23'h5a5a5a, "deselected mode set");
        cmd(CS_ACTIVE, CMD_REF, 23'h0a0a0a, 3'h1);
        repeat (3) @(negedge clk);
        check(mode_cfg, 23'h5a5a5a, "refresh no effect");
        check(rvalid, 1'h0, "refresh no data");
        $display("test commands done");
    endtask : t_cmds
    task automatic t_data;
        wr(3'h3, 4'h4, 18'h1234a, 18'h2b0c5, 1'h0, 1'h0);
        wr(3'h2, 4'h4, 18'h0f0f0, 18'h30303, 1'h0, 1'h0);
        rd_chk(CS_ACTIVE, 3'h3, 4'h4, 18'h1234a, 18'h2b0c5);
        rd_chk(CS_ACTIVE, 3'h2, 4'h4, 18'h0f0f0, 18'h30303);
        wr(3'h3, 4'h4, 18'h3ffff, 18'h00011, MASK_DROP, 1'h0);
        rd_chk(CS_ACTIVE, 3'h3, 4'h4, 18'h1234a, 18'h00011);
        wr(3'h2, 4'h4, 18'h11111, 18'h22222, 1'h0, MASK_DROP);
        rd_chk(CS_ACTIVE, 3'h2, 4'h4, 18'h11111, 18'h30303);
        // an ignored read leaves the last beat of the previous burst on the bus
        rd_chk(1'h1, 3'h3, 4'h4, 18'h30303, 18'h30303);
        $display("test data done");
    endtask : t_data

    initial begin
        // reset spans several write clock edges so the link side sees it
        repeat (30) @(negedge clk);
        srst = 1'h0;
        t_idle();
        t_cmds();
        t_data();
        stop_test();
    end
endmodule : lldp_port_bench
